// ### rsm_consts.vh
// constants for the range shift motor controller
// assumes a 10 MHz system clock and a 100 ms common tick
`ifndef RSM_CONSTS_VH
`define RSM_CONSTS_VH

`define RSM_CLK_HZ 10000000
`define RSM_TICK_MS 100
`define RSM_TICK_CYCLES ((`RSM_CLK_HZ / 1000) * `RSM_TICK_MS)

// interval lengths in milliseconds and in ticks
`define RSM_QUAL_MS 2000
`define RSM_DRIVE_MS 5000
`define RSM_PAUSE_MS 3000
`define RSM_BLINK_MS 300
`define RSM_PERSIST_MS 1000
`define RSM_SPD_WIN_MS 1000
`define RSM_QUAL_TICKS (`RSM_QUAL_MS / `RSM_TICK_MS)
`define RSM_DRIVE_TICKS (`RSM_DRIVE_MS / `RSM_TICK_MS)
`define RSM_PAUSE_TICKS (`RSM_PAUSE_MS / `RSM_TICK_MS)
`define RSM_BLINK_TICKS (`RSM_BLINK_MS / `RSM_TICK_MS)
`define RSM_PERSIST_TICKS (`RSM_PERSIST_MS / `RSM_TICK_MS)
`define RSM_SPD_WIN_TICKS (`RSM_SPD_WIN_MS / `RSM_TICK_MS)

// speed limits in pulses per minute, turned into pulses per window
`define RSM_SHIFT_PPM 2580
`define RSM_LOWRNG_PPM 5220
`define RSM_SHIFT_LIMIT ((`RSM_SHIFT_PPM * `RSM_SPD_WIN_MS) / 60000)
`define RSM_LOWRNG_LIMIT ((`RSM_LOWRNG_PPM * `RSM_SPD_WIN_MS) / 60000)

// encoder position codes, line 1 in bit 3
`define RSM_POS_LSTOP 4'hE
`define RSM_POS_LOFH 4'hA
`define RSM_POS_HIGH 4'h2
`define RSM_POS_ROFH 4'h0
`define RSM_POS_NEUT 4'h9
`define RSM_POS_ZONE2 4'h1
`define RSM_POS_LOW 4'h5
`define RSM_POS_RSTOP 4'h4

// clutch coil duty cycles in percent, pwm period of 100 steps
`define RSM_DUTY_ABS 7'h1E
`define RSM_DUTY_MAX 7'h58
`define RSM_PWM_LAST 7'h63

// attempt numbers of the default sequence
`define RSM_ATT_FIRST 2'h0
`define RSM_ATT_RETRY 2'h1
`define RSM_ATT_RET1 2'h2
`define RSM_ATT_RET2 2'h3

`endif

// ### rsm_controller.v
// range shift motor controller: shift sequencing, lamps, clutch duty, fault supervision
// assumes reset_n follows ignition-on and all pin inputs are asynchronous
// What this block does
// - selector toggle starts a range change
// - position mismatch after ignition starts a change
// - pre-shift check failure abandons the shift
// - neutral 2 s and speeds low before motion
// - lost criteria hold shift; selector return cancels
// - drive toward target until code or fault
// - 5 s drive without target means failure
// - selector, neutral and speed ignored while motor is energised
// - lamp blinks 0.3 s on, 0.3 s off
// - lamp steady per resting position after success
// - first failure: pause 3 s, retry once
// - second failure: pause, return, then lock
// - failed return retried; success lights fault lamp
// - second return fails: motor off, lamp, lock
// - antilock active forces 30 percent coil duty
// - low range above 175 rpm gives 88 percent
// - slip raises duty, then back to touch-off
// - memory self-test failure blocks all, lamp dark
// - calibration fault: lamp, defaults, no codes stored
// - motor/encoder fault reported after one second
// - invalid code or grounded line is encoder fault
// - confirmed invalid code mid-shift: drive high, lock
// - codes 0010 high, 1001 neutral, 0101 low
`timescale 1ns/1ps
`include "rsm_consts.vh"
module rsm_controller #(
  parameter TICK_CYCLES = `RSM_TICK_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // switches and sensors
  input wire range_selector_input,
  input wire neutral_in,
  input wire front_speed_pulse,
  input wire rear_speed_pulse,
  input wire [3:0] enc_line,
  input wire [3:0] enc_line_grounded,
  input wire motor_fault_in,
  input wire speed_sensor_fault,
  input wire antilock_brake_active,
  input wire wheel_slip_detected,
  // memory self-test results
  input wire rom_ram_ok,
  input wire cal_mem_ok,
  // duty requests from torque logic
  input wire [6:0] slip_duty,
  input wire [6:0] touch_off_duty,
  // motor drive pair
  output reg motor_to_low_q,
  output reg motor_to_high_q,
  // lamps
  output reg low_range_lamp_q,
  output reg fault_lamp_q,
  // clutch coil
  output reg clutch_coil_drive_q,
  output reg [6:0] clutch_duty_q,
  // status
  output reg fault_code_store_q,
  output reg use_default_cal_q,
  output reg shifts_inhibited_q
);
  localparam S_IDLE = 3'h0;
  localparam S_QUAL = 3'h1;
  localparam S_DRIVE = 3'h2;
  localparam S_PAUSE = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_TOHIGH = 3'h5;
  localparam S_LOCK = 3'h6;
  localparam SYNC_W = 18;

  // reset release and pin synchronisers
  reg [1:0] rst_q;
  reg run_rst_n_q;
  reg [SYNC_W-1:0] meta_q;
  reg [SYNC_W-1:0] sync_q;
  wire rst_n = rst_q[1];
  wire [SYNC_W-1:0] pins = {range_selector_input, neutral_in, front_speed_pulse, rear_speed_pulse,
    enc_line, enc_line_grounded, motor_fault_in, speed_sensor_fault, antilock_brake_active,
    wheel_slip_detected, rom_ram_ok, cal_mem_ok};

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 2'b00;
      meta_q <= {SYNC_W{1'b0}};
      sync_q <= {SYNC_W{1'b0}};
    end else begin
      rst_q <= {rst_q[0], 1'b1};
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  wire sel_low = sync_q[17];
  wire neutral = sync_q[16];
  wire fspd = sync_q[15];
  wire rspd = sync_q[14];
  wire [3:0] enc = sync_q[13:10];
  wire [3:0] enc_gnd = sync_q[9:6];
  wire motor_flt = sync_q[5];
  wire spd_flt = sync_q[4];
  wire abs_on = sync_q[3];
  wire slip = sync_q[2];
  wire rom_ok = sync_q[1];
  wire cal_ok = sync_q[0];

  // a failing memory test holds everything in reset and retests each cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      run_rst_n_q <= 1'b0;
    else
      run_rst_n_q <= rom_ok;
  end

  wire tick;
  wire f_lo;
  wire f_hi;
  wire r_lo;
  wire r_hi;

  rsm_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .rst_n(run_rst_n_q),
    .tick_q(tick)
  );

  rsm_speed #(.WIN_TICKS(`RSM_SPD_WIN_TICKS), .LIMIT_LO(`RSM_SHIFT_LIMIT), .LIMIT_HI(`RSM_LOWRNG_LIMIT)) u_front (
    .clk_sys(clk_sys),
    .rst_n(run_rst_n_q),
    .tick(tick),
    .pulse(fspd),
    .over_lo_q(f_lo),
    .over_hi_q(f_hi)
  );

  rsm_speed #(.WIN_TICKS(`RSM_SPD_WIN_TICKS), .LIMIT_LO(`RSM_SHIFT_LIMIT), .LIMIT_HI(`RSM_LOWRNG_LIMIT)) u_rear (
    .clk_sys(clk_sys),
    .rst_n(run_rst_n_q),
    .tick(tick),
    .pulse(rspd),
    .over_lo_q(r_lo),
    .over_hi_q(r_hi)
  );

  // encoder decode
  wire pos_high = enc == `RSM_POS_HIGH;
  wire pos_low = enc == `RSM_POS_LOW;
  wire at_low_end = pos_low || enc == `RSM_POS_RSTOP;
  wire at_high_end = pos_high || enc == `RSM_POS_LSTOP || enc == `RSM_POS_LOFH;
  wire code_ok = at_low_end || at_high_end || enc == `RSM_POS_ROFH || enc == `RSM_POS_NEUT ||
    enc == `RSM_POS_ZONE2;
  wire enc_flt = !code_ok || (enc_gnd != 4'h0);
  wire mismatch = sel_low ? !at_low_end : !at_high_end;
  wire spd_over = f_lo || r_lo;

  // fault persistence and recovery
  reg [3:0] state_q;
  reg [3:0] flt_cnt_q;
  reg fault_conf_q;
  reg conf_enc_q;
  reg hard_q;
  reg cal_seen_q;
  reg cal_fault_q;
  wire motor_on = state_q == {1'b0, S_DRIVE} || state_q == {1'b0, S_TOHIGH};
  wire sup_flt = enc_flt || motor_flt;
  wire last_persist = tick && flt_cnt_q == `RSM_PERSIST_TICKS - 1;

  always @(posedge clk_sys or negedge run_rst_n_q) begin
    if (!run_rst_n_q) begin
      flt_cnt_q <= 4'h0;
      fault_conf_q <= 1'b0;
      conf_enc_q <= 1'b0;
      hard_q <= 1'b0;
      fault_code_store_q <= 1'b0;
      cal_seen_q <= 1'b0;
      cal_fault_q <= 1'b0;
    end else begin
      fault_code_store_q <= 1'b0;
      if (!cal_seen_q) begin
        cal_seen_q <= 1'b1;
        cal_fault_q <= !cal_ok;
      end
      if (sup_flt == fault_conf_q || hard_q) begin
        flt_cnt_q <= 4'h0;
      end else if (last_persist) begin
        flt_cnt_q <= 4'h0;
        fault_conf_q <= sup_flt;
        conf_enc_q <= enc_flt;
        // a motor fault confirmed while energised never recovers; one raised in S_DRIVE is confirmed in S_HOLD and clears
        hard_q <= sup_flt && motor_flt && motor_on;
        fault_code_store_q <= sup_flt && !cal_fault_q;
      end else if (tick) begin
        flt_cnt_q <= flt_cnt_q + 4'h1;
      end
    end
  end

  // shift sequencing
  reg [1:0] att_q;
  reg tgt_low_q;
  reg orig_low_q;
  reg [5:0] tmr_q;
  reg sel_prev_q;
  reg init_q;
  reg lock_lamp_q;
  reg rest_low_q;
  reg lock_q;
  wire at_tgt = tgt_low_q ? pos_low : pos_high;
  wire request = init_q ? mismatch : (sel_low != sel_prev_q);
  wire [1:0] att_next = att_q + 2'h1;

  always @(posedge clk_sys or negedge run_rst_n_q) begin
    if (!run_rst_n_q) begin
      state_q <= {1'b0, S_IDLE};
      att_q <= `RSM_ATT_FIRST;
      tgt_low_q <= 1'b0;
      orig_low_q <= 1'b0;
      tmr_q <= 6'h00;
      sel_prev_q <= 1'b0;
      init_q <= 1'b1;
      lock_lamp_q <= 1'b0;
      rest_low_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      case (state_q[2:0])
        S_IDLE: begin
          sel_prev_q <= sel_low;
          init_q <= 1'b0;
          if (init_q) begin
            sel_prev_q <= sel_low;
            rest_low_q <= at_low_end;
          end
          if (fault_conf_q)
            lock_q <= 1'b1;
          if (request && !lock_q && !fault_conf_q && !hard_q) begin
            if (sup_flt || spd_flt) begin
              lock_q <= 1'b1;
            end else begin
              state_q <= {1'b0, S_QUAL};
              tgt_low_q <= sel_low;
              orig_low_q <= !sel_low;
              att_q <= `RSM_ATT_FIRST;
              tmr_q <= 6'h00;
            end
          end
        end
        S_QUAL: begin
          if (sel_low == orig_low_q) begin
            state_q <= {1'b0, S_IDLE};
            sel_prev_q <= sel_low;
          end else if (fault_conf_q) begin
            state_q <= {1'b0, S_IDLE};
            lock_q <= 1'b1;
          end else if (!neutral) begin
            tmr_q <= 6'h00;
          end else if (tmr_q >= `RSM_QUAL_TICKS && !spd_over) begin
            state_q <= {1'b0, S_DRIVE};
            tmr_q <= 6'h00;
          end else if (tick && tmr_q < `RSM_QUAL_TICKS) begin
            tmr_q <= tmr_q + 6'h01;
          end
        end
        S_DRIVE: begin
          // selector, neutral, speed and ignition are not looked at here
          if (at_tgt) begin
            if (att_q == `RSM_ATT_FIRST || att_q == `RSM_ATT_RETRY) begin
              state_q <= {1'b0, S_IDLE};
              rest_low_q <= tgt_low_q;
              sel_prev_q <= tgt_low_q;
            end else begin
              state_q <= {1'b0, S_LOCK};
              lock_lamp_q <= att_q == `RSM_ATT_RET2;
              rest_low_q <= tgt_low_q;
            end
          end else if (sup_flt) begin
            state_q <= {1'b0, S_HOLD};
          end else if (tick && tmr_q == `RSM_DRIVE_TICKS - 1) begin
            tmr_q <= 6'h00;
            if (att_q == `RSM_ATT_RET2) begin
              state_q <= {1'b0, S_LOCK};
              lock_lamp_q <= 1'b1;
            end else begin
              state_q <= {1'b0, S_PAUSE};
            end
          end else if (tick) begin
            tmr_q <= tmr_q + 6'h01;
          end
        end
        S_PAUSE: begin
          if (tick && tmr_q == `RSM_PAUSE_TICKS - 1) begin
            tmr_q <= 6'h00;
            att_q <= att_next;
            state_q <= {1'b0, S_DRIVE};
            if (att_next == `RSM_ATT_RET1)
              tgt_low_q <= orig_low_q;
          end else if (tick) begin
            tmr_q <= tmr_q + 6'h01;
          end
        end
        S_HOLD: begin
          // motor stays off while a fault waits for confirmation
          if (fault_conf_q) begin
            tmr_q <= 6'h00;
            state_q <= conf_enc_q ? {1'b0, S_TOHIGH} : {1'b0, S_LOCK};
          end else if (!sup_flt) begin
            state_q <= {1'b0, S_DRIVE};
          end
        end
        S_TOHIGH: begin
          if (pos_high || (tick && tmr_q == `RSM_DRIVE_TICKS - 1)) begin
            state_q <= {1'b0, S_LOCK};
            rest_low_q <= 1'b0;
          end else if (tick) begin
            tmr_q <= tmr_q + 6'h01;
          end
        end
        S_LOCK: begin
          lock_q <= 1'b1;
        end
        default: begin
          state_q <= {1'b0, S_IDLE};
        end
      endcase
    end
  end

  // outputs: lamps, motor, clutch duty
  reg [1:0] blink_cnt_q;
  reg blink_q;
  reg [6:0] pwm_q;
  wire blinking = state_q == {1'b0, S_QUAL} || state_q == {1'b0, S_DRIVE} ||
    state_q == {1'b0, S_PAUSE} || state_q == {1'b0, S_HOLD};
  wire [6:0] slip_lim = (slip_duty > `RSM_DUTY_MAX) ? `RSM_DUTY_MAX : slip_duty;

  always @(posedge clk_sys or negedge run_rst_n_q) begin
    if (!run_rst_n_q) begin
      blink_cnt_q <= 2'h0;
      blink_q <= 1'b1;
      pwm_q <= 7'h00;
      motor_to_low_q <= 1'b0;
      motor_to_high_q <= 1'b0;
      low_range_lamp_q <= 1'b0;
      fault_lamp_q <= 1'b0;
      clutch_coil_drive_q <= 1'b0;
      clutch_duty_q <= 7'h00;
      use_default_cal_q <= 1'b0;
      shifts_inhibited_q <= 1'b0;
    end else begin
      if (!blinking) begin
        blink_cnt_q <= 2'h0;
        blink_q <= 1'b1;
      end else if (tick && blink_cnt_q == `RSM_BLINK_TICKS - 1) begin
        blink_cnt_q <= 2'h0;
        blink_q <= !blink_q;
      end else if (tick) begin
        blink_cnt_q <= blink_cnt_q + 2'h1;
      end
      low_range_lamp_q <= blinking ? blink_q : rest_low_q;
      fault_lamp_q <= cal_fault_q || fault_conf_q || hard_q || lock_lamp_q;
      motor_to_low_q <= state_q == {1'b0, S_DRIVE} && tgt_low_q;
      motor_to_high_q <= (state_q == {1'b0, S_DRIVE} && !tgt_low_q) || state_q == {1'b0, S_TOHIGH};
      use_default_cal_q <= cal_fault_q;
      shifts_inhibited_q <= lock_q || fault_conf_q || hard_q;
      if (abs_on)
        clutch_duty_q <= `RSM_DUTY_ABS;
      else if (rest_low_q && (f_hi || r_hi))
        clutch_duty_q <= `RSM_DUTY_MAX;
      else if (slip)
        clutch_duty_q <= slip_lim;
      else
        clutch_duty_q <= touch_off_duty;
      pwm_q <= (pwm_q == `RSM_PWM_LAST) ? 7'h00 : pwm_q + 7'h01;
      clutch_coil_drive_q <= pwm_q < clutch_duty_q;
    end
  end
endmodule // rsm_controller

// ### rsm_controller_assertions.sv
// port-level checker for rsm_controller
// assumes a bind from the bench that hands on TICK_CYCLES
`timescale 1ns/1ps
`include "rsm_consts.vh"
module rsm_controller_assertions #(
  parameter TICK_CYCLES = 10
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // inputs
  input wire neutral_in,
  input wire [3:0] enc_line,
  input wire [3:0] enc_line_grounded,
  input wire motor_fault_in,
  input wire antilock_brake_active,
  input wire rom_ram_ok,
  // outputs
  input wire motor_to_low_q,
  input wire motor_to_high_q,
  input wire low_range_lamp_q,
  input wire fault_lamp_q,
  input wire [6:0] clutch_duty_q,
  input wire fault_code_store_q,
  input wire use_default_cal_q,
  input wire shifts_inhibited_q
);
  localparam int QUAL_MIN = 19 * TICK_CYCLES;
  localparam int OFF_MIN = 32 * TICK_CYCLES;
  localparam int PERS_MIN = 9 * TICK_CYCLES;
  localparam int DRV_MAX = 50 * TICK_CYCLES + 4;
  logic [11:0] neut_q, off_q, flt_q, on_q;
  logic [3:0] up_q;
  wire mot = motor_to_low_q | motor_to_high_q;
  wire raw_flt = motor_fault_in | (|enc_line_grounded) | !(enc_line inside {`RSM_POS_LSTOP, `RSM_POS_LOFH,
    `RSM_POS_HIGH, `RSM_POS_ROFH, `RSM_POS_NEUT, `RSM_POS_ZONE2, `RSM_POS_LOW, `RSM_POS_RSTOP});
  function automatic logic [11:0] sat(input logic [11:0] x);
    return (x == 12'hFFF) ? x : x + 12'h001;
  endfunction
  // neut_q, flt_q and up_q run on the raw pins, so they lead the design's synchronised view
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      neut_q <= 12'h000;
      off_q <= 12'h000;
      flt_q <= 12'h000;
      on_q <= 12'h000;
      up_q <= 4'h0;
    end else begin
      neut_q <= neutral_in ? sat(neut_q) : 12'h000;
      off_q <= mot ? 12'h000 : sat(off_q);
      on_q <= mot ? sat(on_q) : 12'h000;
      flt_q <= raw_flt ? sat(flt_q) : 12'h000;
      up_q <= !rom_ram_ok ? 4'h0 : (up_q == 4'hF ? up_q : up_q + 4'h1);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_abs_held; antilock_brake_active [*5]; endsequence
  sequence s_lamp_kept; low_range_lamp_q [*8]; endsequence
  sequence s_mem_bad; !rom_ram_ok [*6]; endsequence
  a_motor_one_way: assert property (!(motor_to_low_q && motor_to_high_q))
    else $error("motor driven both ways");
  a_abs_duty: assert property ((up_q == 4'hF) ##0 s_abs_held |-> clutch_duty_q == `RSM_DUTY_ABS)
    else $error("brake duty wrong");
  a_qual_first: assert property ($rose(mot) && off_q > OFF_MIN |-> neut_q >= QUAL_MIN)
    else $error("motor started before neutral qualified");
  a_blink_hold: assert property ($rose(low_range_lamp_q) |=> s_lamp_kept)
    else $error("range lamp lit too briefly");
  a_fault_persist: assert property ($rose(fault_code_store_q) |-> flt_q >= PERS_MIN)
    else $error("fault stored before persistence");
  a_cal_lamp: assert property (use_default_cal_q && $past(use_default_cal_q) |->
    fault_lamp_q && !fault_code_store_q)
    else $error("calibration fault handling wrong");
  a_mem_block: assert property (s_mem_bad |->
    !mot && !fault_lamp_q && !low_range_lamp_q && clutch_duty_q == 7'h00)
    else $error("outputs active during memory fault");
  a_lock_kept: assert property (shifts_inhibited_q && up_q == 4'hF |=> shifts_inhibited_q)
    else $error("shift lock released");
  a_drive_limit: assert property (on_q <= DRV_MAX)
    else $error("motor on too long");
  a_duty_ceiling: assert property (clutch_duty_q <= `RSM_DUTY_MAX)
    else $error("coil duty above maximum");
endmodule // rsm_controller_assertions

// ### rsm_controller_bench.sv
// self-checking bench for rsm_controller with a behavioural shift motor
// assumes TICK_CYCLES of 20, so a 1 s speed window is 200 clocks
`timescale 1ns/1ps
`include "rsm_consts.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module rsm_controller_bench;
  localparam int T = 20;
  typedef struct {string nm; logic [31:0] e; logic [31:0] g;} note_t;
  logic clk_sys = 0, reset_n = 0, sel = 0, neut = 1, fp = 0, rp = 0, sflt = 0, abs_in = 0, slip = 0;
  logic rom_ok = 1, cal_ok = 1, stall = 0, bad = 0, fast = 0, mflt = 0;
  logic [3:0] gnd = 4'h0;
  logic [6:0] slip_d = 7'h00, touch_d = 7'h00, ex;
  wire [3:0] mot_enc;
  wire [3:0] enc = bad ? 4'hF : mot_enc;
  wire m_low, m_high, lamp, flamp, store, dcal, inh, coil;
  wire [6:0] duty;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  note_t q[$];
  note_t cur_n;
  event look;
  rsm_controller #(.TICK_CYCLES(T)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .range_selector_input(sel),
    .neutral_in(neut), .front_speed_pulse(fp), .rear_speed_pulse(rp), .enc_line(enc), .enc_line_grounded(gnd),
    .motor_fault_in(mflt), .speed_sensor_fault(sflt), .antilock_brake_active(abs_in), .wheel_slip_detected(slip),
    .rom_ram_ok(rom_ok), .cal_mem_ok(cal_ok), .slip_duty(slip_d), .touch_off_duty(touch_d),
    .motor_to_low_q(m_low), .motor_to_high_q(m_high), .low_range_lamp_q(lamp), .fault_lamp_q(flamp),
    .clutch_coil_drive_q(coil), .clutch_duty_q(duty), .fault_code_store_q(store), .use_default_cal_q(dcal),
    .shifts_inhibited_q(inh));
  rsm_motor_model #(.STEP(20), .START(7)) motor (.clk_sys(clk_sys), .to_low(m_low), .to_high(m_high),
    .stall(stall), .enc(mot_enc));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      stop_test;
    end else begin
      #1;
      fp <= fast ? ~fp : ($urandom % 16 == 0);
      rp <= ($urandom % 16 == 0);
    end
  end
  always @(look) begin
    while (q.size() > 0) begin
      cur_n = q.pop_front();
      `CHK(cur_n.nm, cur_n.e, cur_n.g)
    end
  end
  task automatic stop_test;
    $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic note(input string nm, input logic [31:0] e, input logic [31:0] g);
    q.push_back('{nm, e, g});
    -> look;
  endtask
  task automatic wait_mot(input int lim, output int n);
    for (n = 0; n < lim && !(m_low | m_high); n++) cyc(1);
  endtask
  task automatic on_time(output int t);
    for (t = 0; t < 2000 && (m_low | m_high) === 1'b1; t++) cyc(1);
  endtask
  task automatic go(input logic to);
    int t;
    wait_mot(3000, t);
    note("direction", {to, !to}, {m_low, m_high});
    on_time(t);
    cyc(2);
    note("range lamp", to, lamp);
  endtask
  task automatic ign(input logic cal);
    reset_n = 0;
    cal_ok = cal;
    cyc(10);
    reset_n = 1;
    cyc(10);
  endtask
  initial begin
    int t, att;
    logic cur;
    void'($urandom(32'hC78D));
    cyc(10);
    reset_n = 1;
    // motor rests low while the selector says high: shift at power-up
    for (t = 0; t < 500 && lamp !== 1'b1; t++) cyc(1);
    for (t = 0; t < 500 && lamp !== 1'b0; t++) cyc(1);
    for (t = 0; t < 500 && lamp !== 1'b1; t++) cyc(1);
    note("blink dark", 3 * T, t);
    go(1'b0);
    // speed too high, then neutral lost: the shift must wait
    fast = 1;
    sel = 1;
    cyc(500);
    neut = 0;
    cyc(100);
    note("held", 2'b00, {m_low, m_high});
    neut = 1;
    fast = 0;
    go(1'b1);
    for (int i = 0; i < 4; i++) begin
      abs_in = (i == 0);
      fast = (i < 2);
      slip = (i == 2);
      slip_d = 7'($urandom % 100);
      touch_d = 7'($urandom % 89);
      cyc(450);
      ex = (i == 0) ? `RSM_DUTY_ABS : (i == 1) ? `RSM_DUTY_MAX : !slip ? touch_d :
        (slip_d > `RSM_DUTY_MAX) ? `RSM_DUTY_MAX : slip_d;
      note("coil duty", ex, duty);
      // one full pwm period of 100 clocks holds exactly duty high clocks
      t = 0;
      repeat (100) begin
        t += coil;
        cyc(1);
      end
      note("coil pwm", ex, t);
    end
    {fast, slip, abs_in} = 3'h0;
    // grounded encoder line first, then a motor fault with the motor at rest
    for (int f = 0; f < 2; f++) begin
      mflt = (f == 1);
      gnd = (f == 1) ? 4'h0 : 4'h1 << ($urandom % 4);
      cyc(12 * T);
      note("lamp on", 1'b1, flamp);
      {mflt, gnd} = 5'h00;
      cyc(12 * T);
      note("lamp off", 1'b0, flamp);
    end
    rom_ok = 0;
    cyc(20);
    note("mem lamps", 2'b00, {flamp, lamp});
    rom_ok = 1;
    cyc(20);
    // invalid code while driving: park toward high and lock
    sel = 0;
    wait_mot(3000, t);
    bad = 1;
    cyc(10);
    wait_mot(15 * T, t);
    note("park dir", 2'b01, {m_low, m_high});
    bad = 0;
    on_time(t);
    cyc(2);
    note("park lock", 2'b11, {flamp, inh});
    sel = 1;
    cyc(800);
    note("no shift", 2'b00, {m_low, m_high});
    cur = 0;
    for (int k = 0; k < 3; k++) begin
      sel = cur;
      ign(1'b1);
      stall = 1;
      sel = !cur;
      att = (k == 2) ? 4 : k + 3;
      for (int a = 0; a < att; a++) begin
        wait_mot(3000, t);
        if (a > 0) note("pause", 1'b1, t >= 30 * T - 5 && t <= 30 * T + 5);
        if (a == k + 2) stall = 0;
        note("attempt dir", (a < 2) ? {!cur, cur} : {cur, !cur}, {m_low, m_high});
        on_time(t);
        if (a < k + 2) note("attempt time", 1'b1, t >= 50 * T - 5 && t <= 50 * T + 5);
      end
      cyc(5);
      note("default end", {1'b1, k > 0, 2'b00}, {inh, flamp, m_low, m_high});
      stall = 0;
    end
    sflt = 1;
    sel = cur;
    ign(1'b0);
    note("default cal", 2'b11, {dcal, flamp});
    cyc(600);
    note("check fails", 3'b100, {inh, m_low, m_high});
    stop_test;
  end
endmodule // rsm_controller_bench
bind rsm_controller rsm_controller_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_sys, .reset_n, .neutral_in,
  .enc_line, .enc_line_grounded, .motor_fault_in, .antilock_brake_active, .rom_ram_ok, .motor_to_low_q,
  .motor_to_high_q, .low_range_lamp_q, .fault_lamp_q, .clutch_duty_q, .fault_code_store_q, .use_default_cal_q,
  .shifts_inhibited_q);

// ### rsm_motor_model.sv
// behavioural shift motor with four-line position encoder
// assumes the controller's drive pair; one position step per STEP clocks
`timescale 1ns/1ps
`include "rsm_consts.vh"
module rsm_motor_model #(
  parameter STEP = 20,
  parameter START = 7
) (
  // clock and drive
  input wire clk_sys,
  input wire to_low,
  input wire to_high,
  // stall keeps the shaft inside the middle zones, so no end position is reached
  input wire stall,
  // encoder lines
  output logic [3:0] enc
);
  logic [3:0] pos_q = 4'(START);
  logic [3:0] nxt;
  int cnt_q = 0;
  wire mov = to_low ^ to_high;
  always @* begin
    nxt = to_low ? pos_q + 4'h1 : pos_q - 4'h1;
  end
  always @(posedge clk_sys) begin
    cnt_q <= (mov && cnt_q < STEP - 1) ? cnt_q + 1 : 0;
    if (mov && cnt_q == STEP - 1 && nxt <= 4'h8 && (!stall || (nxt >= 4'h3 && nxt <= 4'h6))) begin
      pos_q <= nxt;
    end
  end
  always @* begin
    case (pos_q)
      4'h0: enc = `RSM_POS_LSTOP;
      4'h1: enc = `RSM_POS_LOFH;
      4'h2: enc = `RSM_POS_HIGH;
      4'h3: enc = `RSM_POS_ROFH;
      4'h4: enc = `RSM_POS_LSTOP;
      4'h5: enc = `RSM_POS_NEUT;
      4'h6: enc = `RSM_POS_ZONE2;
      4'h7: enc = `RSM_POS_LOW;
      default: enc = `RSM_POS_RSTOP;
    endcase
  end
endmodule // rsm_motor_model

// ### rsm_speed.v
// propshaft speed check: pulses counted over a fixed window of ticks
// assumes the pulse input is already synchronised to clk_sys
`timescale 1ns/1ps
module rsm_speed #(
  parameter WIN_TICKS = 10,
  parameter LIMIT_LO = 43,
  parameter LIMIT_HI = 87
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire tick,
  // sensor pulse
  input wire pulse,
  // result of the last full window
  output reg over_lo_q,
  output reg over_hi_q
);
  reg pulse_q;
  reg [11:0] cnt_q;
  reg [7:0] win_q;
  wire rise = pulse & ~pulse_q;
  wire win_end = tick && (win_q == WIN_TICKS[7:0] - 8'h01);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
      cnt_q <= 12'h000;
      win_q <= 8'h00;
      over_lo_q <= 1'b0;
      over_hi_q <= 1'b0;
    end else begin
      pulse_q <= pulse;
      if (win_end) begin
        // a pulse on the closing edge is dropped; one count of error is acceptable
        win_q <= 8'h00;
        cnt_q <= 12'h000;
        over_lo_q <= cnt_q > LIMIT_LO[11:0];
        over_hi_q <= cnt_q > LIMIT_HI[11:0];
      end else begin
        if (tick)
          win_q <= win_q + 8'h01;
        if (rise && cnt_q != 12'hFFF)
          cnt_q <= cnt_q + 12'h001;
      end
    end
  end
endmodule // rsm_speed

// ### rsm_tick.v
// common prescaled tick for all second-scale intervals
// assumes clk_sys and a synchronous-domain active low reset
`timescale 1ns/1ps
module rsm_tick #(
  parameter CYCLES = 1000000
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // one-cycle enable
  output reg tick_q
);
  reg [23:0] cnt_q;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (cnt_q == CYCLES[23:0] - 24'h000001) begin
      cnt_q <= 24'h000000;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end
endmodule // rsm_tick
